// ### src/sld_cfg.svh
// header: offsets, field positions, reset values and timing counts of the level detector
// assumes a 10 MHz system clock and a 32-bit APB register bus
`ifndef SLD_CFG_SVH
`define SLD_CFG_SVH

`define SLD_ADDR_STATUS      12'h000
`define SLD_ADDR_CONTROL     12'h004
`define SLD_ADDR_IRQ_STATUS  12'h008
`define SLD_ADDR_IRQ_MASK    12'h00C
`define SLD_ADDR_IRQ_ROUTE   12'h010

`define SLD_STAT_UNDER_BIT   2
`define SLD_STAT_VALID_BIT   1
`define SLD_STAT_ENABLE_BIT  0
`define SLD_CTRL_BAND_BIT    3
`define SLD_CTRL_TRIM_HI     2
`define SLD_CTRL_TRIM_LO     0

`define SLD_STATUS_RESET     8'h00
`define SLD_CONTROL_RESET    8'h00
`define SLD_IRQ_ROUTE_RESET  3'h2

`define SLD_CLK_HZ           10000000
`define SLD_MEAS_TIME_US     2000
`define SLD_MEAS_MAX_US      2500
`define SLD_PULSE_MIN_US     875
`define SLD_PULSE_MAX_US     1350
`define SLD_MEAS_CYCLES      ((`SLD_MEAS_TIME_US * (`SLD_CLK_HZ / 1000000)))
`define SLD_PULSE_CYCLES     ((`SLD_PULSE_MIN_US * (`SLD_CLK_HZ / 1000000)))

`endif

// ### src/sld_pkg.sv
// package: types shared by the level detector files
// assumes the cfg header supplies all numbers
package sld_pkg;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } sld_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sld_apb_rsp_type;

  typedef enum logic [1:0] {
    SLD_OFF    = 2'b00,
    SLD_SETTLE = 2'b01,
    SLD_ACTIVE = 2'b10
  } sld_phase_type;

  typedef struct packed {
    logic       bandSelect;
    logic [2:0] trim;
  } sld_setting_type;

endpackage

// ### src/sld_dip_filter.sv
// dip filter: passes the comparator level only after it has held steady
// assumes the comparator input is synchronous to clk_sys
`timescale 1ns/1ps
`include "sld_cfg.svh"

module sld_dip_filter #(
  parameter int unsigned HOLD_CYCLES = `SLD_PULSE_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic rawLevel,
  output logic      filtLevel
);

  typedef struct packed {
    logic        level;
    logic [15:0] count;
  } sld_filt_state_type;

  sld_filt_state_type state_reg;
  sld_filt_state_type state_next;

  always_comb
  begin
    state_next = state_reg;
    if (!run)
    begin
      state_next.level = 1'b0;
      state_next.count = 16'h0000;
    end
    else if (rawLevel == state_reg.level)
    begin
      state_next.count = 16'h0000;
    end
    else if (state_reg.count >= 16'(HOLD_CYCLES - 1))
    begin
      state_next.level = rawLevel;
      state_next.count = 16'h0000;
    end
    else
    begin
      state_next.count = state_reg.count + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign filtLevel = state_reg.level;

endmodule // sld_dip_filter

// ### src/sld_level_detector.sv
// level detector: APB registers, settling timer, edge interrupt, trim output
// assumes the analog comparator answers belowThreshold synchronously to clk_sys
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "sld_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - detector runs only while enable is one
// - enable starts timer; valid after measurement time
// - after valid, while enabled, undervoltage requests interrupt
// - one interrupt per undervoltage rising edge
// - status: result bit2, valid bit1, enable bit0
// - control: band bit3, trim bits 2..0
// - trim 000 highest, 111 lowest threshold
// - band zero low range, one high
// - low supply irq defaults to position two
// - dips shorter than minimum width ignored
// - timings scale with the system clock
module sld_level_detector #(
  parameter int unsigned MEAS_CYCLES  = `SLD_MEAS_CYCLES,
  parameter int unsigned PULSE_CYCLES = `SLD_PULSE_CYCLES
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire sld_pkg::sld_apb_req_type apbReq,
  output sld_pkg::sld_apb_rsp_type     apbRsp,
  input  wire logic                    belowThreshold,
  output logic                         detectorPowerOn,
  output sld_pkg::sld_setting_type     thresholdSetting,
  output logic                         lowSupplyIrq,
  output logic [7:0]                   midIrqVector
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    sld_pkg::sld_phase_type phase;
    logic [15:0]            timer;
    logic                   monitorEnable;
    logic                   resultValid;
    logic                   underPrev;
    logic                   bandSelect;
    logic [2:0]             trim;
    logic                   irqStatus;
    logic                   irqMask;
    logic [2:0]             irqRoute;
    logic [31:0]            prdata;
  } sld_state_type;

  sld_state_type state_reg;
  sld_state_type state_next;

  logic underFiltered;
  logic underFlag;
  logic accessPhase;
  logic writeHit;
  logic readHit;
  logic [7:0] statusByte;
  logic [7:0] controlByte;

  function automatic logic addrKnown(input logic [11:0] addr);
    addrKnown = (addr == `SLD_ADDR_STATUS) || (addr == `SLD_ADDR_CONTROL) ||
                (addr == `SLD_ADDR_IRQ_STATUS) || (addr == `SLD_ADDR_IRQ_MASK) ||
                (addr == `SLD_ADDR_IRQ_ROUTE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // dip filter

  sld_dip_filter #(
    .HOLD_CYCLES (PULSE_CYCLES)
  ) u_filter (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .run       (state_reg.monitorEnable),
    .rawLevel  (belowThreshold),
    .filtLevel (underFiltered)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register views

  assign underFlag = underFiltered & state_reg.resultValid;

  always_comb
  begin
    statusByte = `SLD_STATUS_RESET;
    statusByte[`SLD_STAT_UNDER_BIT]  = underFlag;
    statusByte[`SLD_STAT_VALID_BIT]  = state_reg.resultValid;
    statusByte[`SLD_STAT_ENABLE_BIT] = state_reg.monitorEnable;
    controlByte = `SLD_CONTROL_RESET;
    controlByte[`SLD_CTRL_BAND_BIT] = state_reg.bandSelect;
    controlByte[`SLD_CTRL_TRIM_HI:`SLD_CTRL_TRIM_LO] = state_reg.trim;
  end

  assign accessPhase = apbReq.psel & apbReq.penable;
  assign writeHit    = accessPhase & apbReq.pwrite;
  assign readHit     = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic edgeEvent;
    edgeEvent  = 1'b0;
    state_next = state_reg;

    // control writes
    if (writeHit)
    begin
      unique case (apbReq.paddr)
        `SLD_ADDR_STATUS:
          state_next.monitorEnable = apbReq.pwdata[`SLD_STAT_ENABLE_BIT];
        `SLD_ADDR_CONTROL:
        begin
          state_next.bandSelect = apbReq.pwdata[`SLD_CTRL_BAND_BIT];
          state_next.trim = apbReq.pwdata[`SLD_CTRL_TRIM_HI:`SLD_CTRL_TRIM_LO];
        end
        `SLD_ADDR_IRQ_STATUS:
          if (apbReq.pwdata[0])
            state_next.irqStatus = 1'b0;
        `SLD_ADDR_IRQ_MASK:
          state_next.irqMask = apbReq.pwdata[0];
        `SLD_ADDR_IRQ_ROUTE:
          state_next.irqRoute = apbReq.pwdata[2:0];
        default:
          state_next.irqRoute = state_reg.irqRoute;
      endcase
    end

    // measurement sequence
    unique case (state_reg.phase)
      sld_pkg::SLD_OFF:
      begin
        state_next.timer       = 16'h0000;
        state_next.resultValid = 1'b0;
        if (state_next.monitorEnable)
          state_next.phase = sld_pkg::SLD_SETTLE;
      end
      sld_pkg::SLD_SETTLE:
      begin
        if (!state_next.monitorEnable)
        begin
          state_next.phase = sld_pkg::SLD_OFF;
          state_next.timer = 16'h0000;
        end
        else if (state_reg.timer >= 16'(MEAS_CYCLES - 1))
        begin
          state_next.phase       = sld_pkg::SLD_ACTIVE;
          state_next.resultValid = 1'b1;
        end
        else
          state_next.timer = state_reg.timer + 16'h0001;
      end
      sld_pkg::SLD_ACTIVE:
      begin
        if (!state_next.monitorEnable)
        begin
          state_next.phase       = sld_pkg::SLD_OFF;
          state_next.resultValid = 1'b0;
          state_next.timer       = 16'h0000;
        end
      end
      default:
        state_next.phase = sld_pkg::SLD_OFF;
    endcase

    // edge interrupt; set wins over clear
    state_next.underPrev = underFlag;
    edgeEvent = underFlag & ~state_reg.underPrev & state_reg.monitorEnable;
    if (edgeEvent)
      state_next.irqStatus = 1'b1;

    // read data captured in setup phase
    if (readHit)
    begin
      unique case (apbReq.paddr)
        `SLD_ADDR_STATUS:     state_next.prdata = {24'h000000, statusByte};
        `SLD_ADDR_CONTROL:    state_next.prdata = {24'h000000, controlByte};
        `SLD_ADDR_IRQ_STATUS: state_next.prdata = {31'h0, state_reg.irqStatus};
        `SLD_ADDR_IRQ_MASK:   state_next.prdata = {31'h0, state_reg.irqMask};
        `SLD_ADDR_IRQ_ROUTE:  state_next.prdata = {29'h0, state_reg.irqRoute};
        default:              state_next.prdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg          <= '0;
      state_reg.phase    <= sld_pkg::SLD_OFF;
      state_reg.irqRoute <= `SLD_IRQ_ROUTE_RESET;
    end
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign apbRsp.prdata  = state_reg.prdata;
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = accessPhase & ~addrKnown(apbReq.paddr);

  assign detectorPowerOn              = state_reg.monitorEnable;
  assign thresholdSetting.bandSelect  = state_reg.bandSelect;
  assign thresholdSetting.trim        = state_reg.trim;
  assign lowSupplyIrq                 = state_reg.irqStatus & state_reg.irqMask;

  always_comb
  begin
    midIrqVector = 8'h00;
    midIrqVector[state_reg.irqRoute] = lowSupplyIrq;
  end

endmodule // sld_level_detector

// ### verif/sld_level_detector_asserts.sv
// checker: port properties of the level detector
// assumes a bind onto sld_level_detector, one clock domain
`timescale 1ns/1ps
module sld_level_detector_asserts #(
  parameter int unsigned MEAS_CYCLES  = 20,
  parameter int unsigned PULSE_CYCLES = 4
) (
  input wire logic                     clk_sys,
  input wire logic                     rst_n,
  input wire sld_pkg::sld_apb_req_type apbReq,
  input wire sld_pkg::sld_apb_rsp_type apbRsp,
  input wire logic                     belowThreshold,
  input wire logic                     detectorPowerOn,
  input wire sld_pkg::sld_setting_type thresholdSetting,
  input wire logic                     lowSupplyIrq,
  input wire logic [7:0]               midIrqVector
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic acc;
  logic statusWr;
  int   enCnt;
  int   belowCnt;
  assign acc = apbReq.psel && apbReq.penable;
  assign statusWr = acc && apbReq.pwrite && apbReq.paddr == 12'h000;
  // cycles since the enable bit was set
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      enCnt <= 0;
    else
      enCnt <= detectorPowerOn ? enCnt + 1 : 0;
  // cycles the comparator level has stayed high
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      belowCnt <= 0;
    else
      belowCnt <= belowThreshold ? belowCnt + 1 : 0;
  //////////////////////////////////////////////////////////////
  a_power_on: assert property ($rose(detectorPowerOn) |->
    $past(statusWr && apbReq.pwdata[0])) else $error("enable rose without write");
  a_power_off: assert property (statusWr && !apbReq.pwdata[0] |=>
    !detectorPowerOn [*2]) else $error("detector still powered");
  a_setting_write: assert property (acc && apbReq.pwrite && apbReq.paddr == 12'h004
    |=> thresholdSetting == $past(apbReq.pwdata[3:0])) else $error("setting not taken");
  a_irq_late: assert property ($rose(lowSupplyIrq) |-> enCnt > MEAS_CYCLES)
    else $error("irq before settling");
  a_irq_enabled: assert property ($rose(lowSupplyIrq) |-> detectorPowerOn)
    else $error("irq while disabled");
  a_irq_sticky: assert property (lowSupplyIrq && !(acc && apbReq.pwrite &&
    apbReq.paddr inside {12'h008, 12'h00C}) |=> lowSupplyIrq) else $error("irq dropped");
  a_status_read: assert property (acc && !apbReq.pwrite && apbReq.paddr == 12'h000
    |-> apbRsp.prdata[31:3] == 0 && apbRsp.prdata[0] == $past(detectorPowerOn)
    && (!apbRsp.prdata[2] || apbRsp.prdata[1])) else $error("bad status read");
  a_irq_vector: assert property ($onehot0(midIrqVector) &&
    ((|midIrqVector) == lowSupplyIrq)) else $error("bad irq vector");
  cover property ($rose(lowSupplyIrq));
  cover property (statusWr && !apbReq.pwdata[0]);
  cover property (acc && apbRsp.pslverr);
  cover property ($fell(belowThreshold) && belowCnt > 0 && belowCnt < PULSE_CYCLES);
endmodule // sld_level_detector_asserts

bind sld_level_detector sld_level_detector_asserts #(
  .MEAS_CYCLES(MEAS_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)
) chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
  .belowThreshold(belowThreshold), .detectorPowerOn(detectorPowerOn),
  .thresholdSetting(thresholdSetting), .lowSupplyIrq(lowSupplyIrq),
  .midIrqVector(midIrqVector)
);

// ### verif/sld_level_detector_bench.sv
// bench: registers, settling, edge interrupts and dip filter
// assumes short timing parameters and an APB slave
`timescale 1ns/1ps
module sld_level_detector_bench;
  localparam int unsigned MEAS = 20;
  localparam int unsigned PULSE = 4;
  logic                     clk_sys = 0;
  logic                     rst_n = 0;
  logic                     belowThreshold = 0;
  sld_pkg::sld_apb_req_type req = '0;
  sld_pkg::sld_apb_rsp_type rsp;
  sld_pkg::sld_setting_type setting;
  logic                     detectorPowerOn;
  logic                     lowSupplyIrq;
  logic [7:0]               midIrqVector;
  logic [33:0]              expQ[$];
  logic [33:0]              ex;
  logic [31:0]              d;
  logic [2:0]               routeExp = 3'h2;
  int                       n_mismatch = 0;
  int                       checks_done = 0;

  always #50 clk_sys = ~clk_sys;

  sld_level_detector #(.MEAS_CYCLES(MEAS), .PULSE_CYCLES(PULSE)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .apbReq(req), .apbRsp(rsp),
    .belowThreshold(belowThreshold), .detectorPowerOn(detectorPowerOn),
    .thresholdSetting(setting), .lowSupplyIrq(lowSupplyIrq), .midIrqVector(midIrqVector));

  task automatic end_of_test();
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one APB transfer; a read notes {pslverr, irq, prdata}
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] v,
                     input logic [33:0] e);
    int i;
    @(posedge clk_sys);
    req <= '{a, 1'b1, 1'b0, w, v};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    if (!w)
      expQ.push_back(e);
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk_sys);
      if (rsp.pready)
        break;
    end
    if (i == 50)
    begin
      n_mismatch++;
      $display("[FAIL] pready exp 1 got 0");
      end_of_test();
    end
    else
    begin
      req.psel <= 1'b0;
      req.penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    bus(a, 1'b1, v, '0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    bus(a, 1'b0, '0, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  //////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
  begin
    if (req.psel && req.penable && !req.pwrite && rsp.pready)
    begin
      ex = expQ.pop_front();
      checks_done++;
      if ({rsp.pslverr, lowSupplyIrq, rsp.prdata} !== ex)
      begin
        n_mismatch++;
        $display("[FAIL] read %h exp %h got %h", req.paddr, ex,
                 {rsp.pslverr, lowSupplyIrq, rsp.prdata});
      end
      if (midIrqVector !== ({7'h00, ex[32]} << routeExp))
      begin
        n_mismatch++;
        $display("[FAIL] midIrqVector exp %h got %h", {7'h00, ex[32]} << routeExp,
                 midIrqVector);
      end
      if (req.paddr == 12'h000 && detectorPowerOn !== ex[0])
      begin
        n_mismatch++;
        $display("[FAIL] detectorPowerOn exp %h got %h", ex[0], detectorPowerOn);
      end
      if (req.paddr == 12'h004 && setting !== ex[3:0])
      begin
        n_mismatch++;
        $display("[FAIL] thresholdSetting exp %h got %h", ex[3:0], setting);
      end
    end
  end

  initial
  begin
    d = $urandom(32'h96786be1);
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(12'h000, 34'h0);
    rd(12'h004, 34'h0);
    rd(12'h010, 34'h2);
    rd(12'h014, {2'b10, 32'h0});
    for (int k = 0; k < 16; k++)
    begin
      d = {$urandom} & 32'hFFFFFFF0 | k;
      wr(12'h004, d);
      rd(12'h004, {30'h0, d[3:0]});
    end
    belowThreshold <= 1'b1;
    wr(12'h00C, 32'h1);
    wr(12'h000, 32'h1);
    rd(12'h000, 34'h1);
    rd(12'h000, 34'h1);
    tick(MEAS + PULSE);
    rd(12'h000, {2'b01, 32'h7});
    wr(12'h008, 32'h1);
    tick(10);
    rd(12'h008, 34'h0);
    belowThreshold <= 1'b0;
    tick(8);
    belowThreshold <= 1'b1;
    tick(2);
    belowThreshold <= 1'b0;
    tick(8);
    rd(12'h000, 34'h3);
    rd(12'h008, 34'h0);
    wr(12'h00C, 32'h0);
    belowThreshold <= 1'b1;
    tick(8);
    rd(12'h008, 34'h1);
    wr(12'h008, 32'h1);
    wr(12'h00C, 32'h1);
    wr(12'h010, 32'h5);
    routeExp = 3'h5;
    rd(12'h010, 34'h5);
    belowThreshold <= 1'b0;
    tick(8);
    belowThreshold <= 1'b1;
    tick(8);
    rd(12'h008, {2'b01, 32'h1});
    wr(12'h008, 32'h1);
    wr(12'h000, 32'h0);
    rd(12'h000, 34'h0);
    wr(12'h000, 32'h1);
    tick(10);
    rd(12'h000, 34'h1);
    rst_n <= 1'b0;
    routeExp = 3'h2;
    tick(3);
    rst_n <= 1'b1;
    rd(12'h010, 34'h2);
    rd(12'h000, 34'h0);
    rd(12'h004, 34'h0);
    end_of_test();
  end
endmodule // sld_level_detector_bench
